// ==== hdl/lpcd_pkg.sv ====
// Package of constants, types and field layouts for the command decoder.
package lpcd_pkg;

    // ==========================================================
    // Bus and field widths
    localparam int CA_W = 10;
    localparam int OPC_W = 4;
    localparam int ROW_W = 15;
    localparam int COL_W = 12;
    localparam int BANK_W = 3;
    localparam int MRA_W = 8;
    localparam int PAY_W = 8;
    localparam int NUM_BANKS = 8;

    // ==========================================================
    // Field positions on the rising half of the command.
    localparam int R_OPC_LSB = 0;
    localparam int R_OPC_MSB = 3;
    localparam int R_ROWHI_LSB = 2;
    localparam int R_ROWHI_MSB = 6;
    localparam int R_BANK_LSB = 7;
    localparam int R_BANK_MSB = 9;
    localparam int R_COL_LSB = 5;
    localparam int R_COL_MSB = 6;
    localparam int R_MRA_LSB = 4;
    localparam int R_MRA_MSB = 9;
    localparam int R_ALLBANK = 4;

    // Field positions on the falling half of the command.
    localparam int F_AP = 0;
    localparam int F_COL_LSB = 1;
    localparam int F_COL_MSB = 9;
    localparam int F_ROWLO_LSB = 0;
    localparam int F_ROWLO_MSB = 7;
    localparam int F_ROWTOP_LSB = 8;
    localparam int F_ROWTOP_MSB = 9;
    localparam int F_MRA_LSB = 0;
    localparam int F_MRA_MSB = 1;
    localparam int F_PAY_LSB = 2;
    localparam int F_PAY_MSB = 9;

    // Column bit 0 never travels on the bus.
    localparam logic COL0_VALUE = 1'h0;

    // ==========================================================
    // Opcode patterns of CA3..CA0, bit 0 is CA0; ? marks operand bits.
    localparam logic [OPC_W-1:0] OPC_MRW = 4'h0;
    localparam logic [OPC_W-1:0] OPC_MRR = 4'h8;
    localparam logic [OPC_W-1:0] OPC_REF_PB = 4'h4;
    localparam logic [OPC_W-1:0] OPC_REF_AB = 4'hc;
    localparam logic [OPC_W-1:0] OPC_ACT = 4'b??10;
    localparam logic [OPC_W-1:0] OPC_WR = 4'b?001;
    localparam logic [OPC_W-1:0] OPC_RD = 4'b?101;
    localparam logic [OPC_W-1:0] OPC_PRE = 4'hb;
    localparam logic [OPC_W-1:0] OPC_BST = 4'h3;
    localparam logic [OPC_W-1:0] OPC_NOP = 4'b?111;
    localparam logic [OPC_W-1:0] OPC_SELF_REFRESH = 4'hc;
    localparam logic [OPC_W-1:0] OPC_DPD = 4'b?011;

    // ==========================================================
    // Decoded command kinds.
    typedef enum logic [3:0] {
        K_NOP = 4'h0,
        K_MRW = 4'h1,
        K_MRR = 4'h2,
        K_REF_PB = 4'h3,
        K_REF_AB = 4'h4,
        K_ACT = 4'h5,
        K_WR = 4'h6,
        K_RD = 4'h7,
        K_PRE = 4'h8,
        K_BST = 4'h9,
        K_SELF_REFRESH_IN = 4'ha,
        K_DPD_IN = 4'hb,
        K_PD_IN = 4'hc,
        K_PD_OUT = 4'hd,
        K_ILLEGAL = 4'hf
    } lpcd_kind_t;

    // Power condition of the device.
    typedef enum logic [1:0] {
        P_ON = 2'h0,
        P_PD = 2'h1,
        P_SELF_REFRESH = 2'h2,
        P_DPD = 2'h3
    } lpcd_pwr_t;

    // Halves of the two-sample command.
    typedef enum logic [0:0] {
        S_RISE = 1'h0,
        S_FALL = 1'h1
    } lpcd_phase_t;

    // Pins as they arrive from the controller.
    typedef struct packed {
        logic ck;
        logic cs_n;
        logic cke;
        logic [CA_W-1:0] ca;
    } lpcd_pins_t;

    // One decoded command with all its fields.
    typedef struct packed {
        logic valid;
        lpcd_kind_t kind;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [MRA_W-1:0] mra;
        logic [PAY_W-1:0] payload;
        logic auto_precharge_flag;
        logic all_bank_select;
    } lpcd_cmd_t;

endpackage

// ==== hdl/lpcd_sync.sv ====
// Three-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module lpcd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Pins from outside the clock domain.
    input wire logic [WIDTH-1:0] i_async,
    // Second and third stages for agreement checks.
    output logic [WIDTH-1:0] o_stage2,
    output logic [WIDTH-1:0] o_stage3
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;

    // ==========================================================
    // Stage chain
    // Each bit is its own chain; the first stage feeds only the second.
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                meta_ff[g] <= 1'h0;
                stage2_ff[g] <= 1'h0;
                stage3_ff[g] <= 1'h0;
            end else begin
                meta_ff[g] <= i_async[g];
                stage2_ff[g] <= meta_ff[g];
                stage3_ff[g] <= stage2_ff[g];
            end
        end
    end

    assign o_stage2 = stage2_ff;
    assign o_stage3 = stage3_ff;

endmodule
`default_nettype wire

// ==== hdl/lpcd_decoder.sv ====
// Command/address decoder: recovers commands from the two-edge command bus.
//
// Operation
// R1 - Command kind from chip select, CA0-CA3, CKE.
// R2 - Chip select and CKE only on rising edge.
// R3 - Command spans rising then falling bus sample.
// R4 - Mode write: CKE high, select low, CA0-3 low.
// R5 - Mode address: CA4-9 rising, CA0-1 falling.
// R6 - Mode payload on falling CA2-9; read ignores.
// R7 - Activate: row high bits, bank on rising.
// R8 - Activate falling: row low and top bits.
// R9 - Read/write opcode, column 1-2, bank rising.
// R10 - Falling: auto precharge flag, column 3-11.
// R11 - Auto precharge flag precharges addressed bank.
// R12 - Column bit zero always taken as zero.
// R13 - Bank field selects the single target bank.
// R14 - Precharge: opcode, all-bank flag, bank rising.
// R15 - Per-bank refresh only with eight banks.
// R16 - Low-power exits detected without clock edges.
// R17 - Controller drives don't-care bits to levels.
// R18 - Controller issues only defined encodings, timings.
// R19 - After illegal event controller reinitialises device.
// R20 - After power-down exit, only NOPs meanwhile.
// R21 - After self refresh exit, only NOPs meanwhile.
// R22 - Register rising half, join falling, present.
`timescale 1ns/1ps
`default_nettype none
module lpcd_decoder #(
    parameter int BANKS = lpcd_pkg::NUM_BANKS
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Pins from the memory controller.
    input wire lpcd_pkg::lpcd_pins_t i_pins,
    // Decoded command toward the bank state logic.
    output lpcd_pkg::lpcd_cmd_t o_cmd,
    output logic [lpcd_pkg::NUM_BANKS-1:0] o_bank_sel,
    output logic o_precharge_after,
    // Power condition and error report.
    output lpcd_pkg::lpcd_pwr_t o_pwr_state,
    output logic o_exit_pulse,
    output lpcd_pkg::lpcd_pwr_t o_exit_from,
    output logic o_illegal
);
    import lpcd_pkg::*;

    // ==========================================================
    // State of the decoder.
    typedef struct packed {
        logic ck_lvl;
        logic cke_lvl;
        logic cke_prev;
        lpcd_phase_t phase;
        lpcd_kind_t rise_kind;
        logic [CA_W-1:0] rise_ca;
        lpcd_pwr_t pwr;
        lpcd_cmd_t cmd;
        logic [NUM_BANKS-1:0] bank_sel;
        logic precharge_after;
        logic exit_pulse;
        lpcd_pwr_t exit_from;
        logic illegal;
    } lpcd_state_t;

    lpcd_state_t state_ff;
    lpcd_state_t nxt_state;
    lpcd_pins_t s2;
    lpcd_pins_t s3;

    // ==========================================================
    // Pin synchroniser.
    // All pins go through one synchroniser of equal depth, so CK, select and CA stay aligned.
    lpcd_sync #(
        .WIDTH($bits(lpcd_pins_t))
    ) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(i_pins),
        .o_stage2(s2),
        .o_stage3(s3)
    );

    // ==========================================================
    // Decode functions.
    // Rising-edge decode from chip select, CKE pair and CA0-CA3 only.
    // CKE pair: high-high runs, high-low enters a low-power state,
    // low-low holds it and low-high leaves it with a deselect.
    function automatic lpcd_kind_t decode_rise(input logic cke_p, input logic cke_n,
                                               input logic cs_n, input logic [OPC_W-1:0] opc);
        lpcd_kind_t k;
        k = K_ILLEGAL;
        if (cke_p && cke_n) begin
            if (cs_n) begin
                k = K_NOP;
            end else begin
                casez (opc) // [R1]
                    OPC_MRW: k = K_MRW; // [R4]
                    OPC_MRR: k = K_MRR;
                    OPC_REF_PB: k = (BANKS == NUM_BANKS) ? K_REF_PB : K_ILLEGAL; // [R15]
                    OPC_REF_AB: k = K_REF_AB;
                    OPC_ACT: k = K_ACT; // [R7]
                    OPC_WR: k = K_WR; // [R9]
                    OPC_RD: k = K_RD; // [R9]
                    OPC_PRE: k = K_PRE; // [R14]
                    OPC_BST: k = K_BST;
                    OPC_NOP: k = K_NOP;
                    default: k = K_ILLEGAL;
                endcase
            end
        end else if (cke_p && !cke_n) begin
            if (cs_n) begin
                k = K_PD_IN;
            end else if (opc == OPC_SELF_REFRESH) begin
                k = K_SELF_REFRESH_IN;
            end else if (opc ==? OPC_DPD) begin
                k = K_DPD_IN;
            end
        end else if (!cke_p && !cke_n) begin
            // Holding a low-power state: only deselect or a NOP pattern is legal.
            if (cs_n || (opc ==? OPC_NOP)) begin
                k = K_NOP;
            end
        end else begin
            if (cs_n) begin
                k = K_PD_OUT;
            end
        end
        return k;
    endfunction

    // One-hot select of the addressed bank.
    // Shared by every bank-directed command.
    function automatic logic [NUM_BANKS-1:0] bank_onehot(input logic [BANK_W-1:0] ba);
        logic [NUM_BANKS-1:0] v;
        v = '0;
        v[ba] = 1'h1;
        return v;
    endfunction

    // ==========================================================
    // Next-state logic.
    // CK and CKE edges count only once stages two and three agree, so a
    // pin caught mid-transition cannot make a false edge. The price is a
    // latency of about four system clocks, so CK must stay well below
    // a quarter of the 50 MHz system rate.
    logic ck_rise;
    logic ck_fall;
    logic cke_stable_hi;
    logic cke_stable_lo;
    logic [BANK_W-1:0] rbank;
    logic [CA_W-1:0] f;
    logic [CA_W-1:0] r;

    always_comb begin
        nxt_state = state_ff;
        ck_rise = s2.ck && s3.ck && !state_ff.ck_lvl;
        ck_fall = !s2.ck && !s3.ck && state_ff.ck_lvl;
        cke_stable_hi = s2.cke && s3.cke;
        cke_stable_lo = !s2.cke && !s3.cke;
        r = state_ff.rise_ca;
        f = s3.ca;
        rbank = r[R_BANK_MSB:R_BANK_LSB];

        // Single-cycle outputs fall back each cycle.
        nxt_state.cmd.valid = 1'h0;
        nxt_state.exit_pulse = 1'h0;
        nxt_state.precharge_after = 1'h0;

        if (s2.ck == s3.ck) begin
            nxt_state.ck_lvl = s3.ck;
        end
        if (cke_stable_hi) begin
            nxt_state.cke_lvl = 1'h1;
        end else if (cke_stable_lo) begin
            nxt_state.cke_lvl = 1'h0;
        end

        // Low-power exit is seen from the CKE level alone, with no CK edge.
        // CK may stay parked during sleep, so waiting for an edge could hang.
        if (state_ff.pwr != P_ON && cke_stable_hi) begin // [R16]
            nxt_state.pwr = P_ON;
            nxt_state.exit_pulse = 1'h1;
            nxt_state.exit_from = state_ff.pwr;
        end

        case (state_ff.phase)
            S_RISE: begin
                if (ck_rise) begin
                    // Chip select and CKE are taken only at this edge. CKE is the
                    // filtered level at this edge, since it may move together with CK.
                    nxt_state.cke_prev = nxt_state.cke_lvl; // [R2]
                    nxt_state.rise_kind = decode_rise(state_ff.cke_prev, nxt_state.cke_lvl,
                                                      s3.cs_n,
                                                      s3.ca[R_OPC_MSB:R_OPC_LSB]); // [R1]
                    nxt_state.rise_ca = s3.ca; // [R22]
                    nxt_state.phase = S_FALL; // [R3]
                end
            end
            S_FALL: begin
                if (ck_fall) begin
                    // Join both halves into one command.
                    nxt_state.phase = S_RISE; // [R3]
                    nxt_state.cmd.valid = 1'h1; // [R22]
                    nxt_state.cmd.kind = state_ff.rise_kind;
                    // Fields a command does not carry read as zero, never stale.
                    nxt_state.cmd.bank = '0;
                    nxt_state.cmd.row = '0;
                    nxt_state.cmd.col = '0;
                    nxt_state.cmd.mra = '0;
                    nxt_state.cmd.payload = '0;
                    nxt_state.cmd.auto_precharge_flag = 1'h0;
                    nxt_state.cmd.all_bank_select = 1'h0;
                    nxt_state.bank_sel = '0;
                    case (state_ff.rise_kind)
                        K_MRW, K_MRR: begin
                            nxt_state.cmd.mra = {f[F_MRA_MSB:F_MRA_LSB],
                                                 r[R_MRA_MSB:R_MRA_LSB]}; // [R5]
                            if (state_ff.rise_kind == K_MRW) begin
                                nxt_state.cmd.payload = f[F_PAY_MSB:F_PAY_LSB]; // [R6]
                            end
                        end
                        K_ACT: begin
                            nxt_state.cmd.bank = rbank; // [R7]
                            nxt_state.cmd.row = {f[F_ROWTOP_MSB:F_ROWTOP_LSB],
                                                 r[R_ROWHI_MSB:R_ROWHI_LSB],
                                                 f[F_ROWLO_MSB:F_ROWLO_LSB]}; // [R8]
                            nxt_state.bank_sel = bank_onehot(rbank); // [R13]
                        end
                        K_WR, K_RD: begin
                            nxt_state.cmd.bank = rbank; // [R9]
                            nxt_state.cmd.col = {f[F_COL_MSB:F_COL_LSB],
                                                 r[R_COL_MSB:R_COL_LSB],
                                                 COL0_VALUE}; // [R10] [R12]
                            nxt_state.cmd.auto_precharge_flag = f[F_AP]; // [R10]
                            // Bank logic closes this bank once the burst is done.
                            nxt_state.precharge_after = f[F_AP]; // [R11]
                            nxt_state.bank_sel = bank_onehot(rbank); // [R13]
                        end
                        K_PRE: begin
                            nxt_state.cmd.bank = rbank; // [R14]
                            nxt_state.cmd.all_bank_select = r[R_ALLBANK]; // [R14]
                            // All-bank precharge selects every bank at once.
                            nxt_state.bank_sel = r[R_ALLBANK] ? '1 : bank_onehot(rbank); // [R13]
                        end
                        K_REF_PB: begin
                            nxt_state.cmd.bank = rbank; // [R15]
                            nxt_state.bank_sel = bank_onehot(rbank); // [R13]
                        end
                        K_SELF_REFRESH_IN: nxt_state.pwr = P_SELF_REFRESH;
                        K_DPD_IN: nxt_state.pwr = P_DPD;
                        K_PD_IN: nxt_state.pwr = P_PD;
                        default: begin
                        end
                    endcase
                    // Illegal events stay flagged until reset; only a full restart clears them.
                    // A sticky flag lets slow firmware see a one-command fault.
                    if (state_ff.rise_kind == K_ILLEGAL) begin
                        nxt_state.illegal = 1'h1; // [R19]
                    end
                end
            end
            default: nxt_state.phase = S_RISE;
        endcase

        if (i_sys_rst) begin
            nxt_state = '0;
            nxt_state.phase = S_RISE;
            nxt_state.pwr = P_ON;
            nxt_state.exit_from = P_ON;
            nxt_state.rise_kind = K_NOP;
            nxt_state.cmd.kind = K_NOP;
            // CKE idles high, so the first command after reset must not
            // look like a power-down exit and be refused.
            nxt_state.cke_lvl = 1'h1;
            nxt_state.cke_prev = 1'h1;
        end
    end

    // ==========================================================
    // State register.
    always_ff @(posedge i_clk) begin
        state_ff <= nxt_state;
    end

    // Outputs straight from the state register.
    // No output passes through logic, so none can glitch downstream.
    assign o_cmd = state_ff.cmd;
    assign o_bank_sel = state_ff.bank_sel;
    assign o_precharge_after = state_ff.precharge_after;
    assign o_pwr_state = state_ff.pwr;
    assign o_exit_pulse = state_ff.exit_pulse;
    assign o_exit_from = state_ff.exit_from;
    assign o_illegal = state_ff.illegal;

endmodule
`default_nettype wire

// ==== tb/lpcd_decoder_sva.sv ====
// Concurrent checks on the ports of the command decoder.
`timescale 1ns/1ps
`default_nettype none
module lpcd_decoder_sva #(
    parameter int BANKS = 8
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Watched pins and outputs.
    input wire lpcd_pkg::lpcd_pins_t i_pins,
    input wire lpcd_pkg::lpcd_cmd_t o_cmd,
    input wire logic [lpcd_pkg::NUM_BANKS-1:0] o_bank_sel,
    input wire logic o_precharge_after,
    input wire lpcd_pkg::lpcd_pwr_t o_pwr_state,
    input wire logic o_exit_pulse,
    input wire lpcd_pkg::lpcd_pwr_t o_exit_from,
    input wire logic o_illegal
);
    import lpcd_pkg::*;
    // ==========================================================
    // One clock domain, so clocking and reset are declared once.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic rw;
    // A decoded column access, the only kind that may carry auto precharge.
    assign rw = o_cmd.valid && (o_cmd.kind == K_RD || o_cmd.kind == K_WR);

    valid_one_cycle_a: assert property (o_cmd.valid |=> !o_cmd.valid)
        else $error("valid held longer than one cycle");
    valid_after_fall_a: assert property (o_cmd.valid |-> !i_pins.ck && !$past(i_pins.ck, 2))
        else $error("command presented before the falling half");
    precharge_tie_a: assert property (o_precharge_after == (rw && o_cmd.auto_precharge_flag))
        else $error("precharge pulse does not match the flag");
    col_zero_a: assert property (rw |-> o_cmd.col[0] == COL0_VALUE)
        else $error("column bit zero not zero");
    bank_onehot_a: assert property (
        o_cmd.valid && o_cmd.kind inside {K_ACT, K_RD, K_WR, K_REF_PB}
        |-> o_bank_sel == (8'h01 << o_cmd.bank))
        else $error("bank select not one-hot of bank field");
    pre_select_a: assert property (o_cmd.valid && o_cmd.kind == K_PRE
        |-> o_bank_sel == (o_cmd.all_bank_select ? 8'hff : 8'h01 << o_cmd.bank))
        else $error("precharge bank select wrong");
    mrr_payload_a: assert property (o_cmd.valid && o_cmd.kind == K_MRR |-> o_cmd.payload == 8'h00)
        else $error("mode read carries a payload");
    illegal_flag_a: assert property (o_cmd.valid && o_cmd.kind == K_ILLEGAL |-> ##[0:1] o_illegal)
        else $error("illegal command not flagged");
    illegal_sticky_a: assert property (o_illegal |=> o_illegal)
        else $error("illegal flag dropped without reset");
    exit_report_a: assert property (o_exit_pulse |-> o_pwr_state == P_ON
        && o_exit_from == $past(o_pwr_state) && o_exit_from != P_ON)
        else $error("exit report inconsistent");
    exit_hold_a: assert property (o_pwr_state != P_ON && !i_pins.cke |=> !o_exit_pulse)
        else $error("exit while clock enable low");

    // Main scenarios reached.
    cover property (o_cmd.valid && o_cmd.kind == K_ACT);
    cover property (o_precharge_after);
    cover property (o_exit_pulse);
    cover property ($rose(o_illegal));
endmodule

bind lpcd_decoder lpcd_decoder_sva #(.BANKS(BANKS)) u_sva (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pins(i_pins),
    .o_cmd(o_cmd),
    .o_bank_sel(o_bank_sel),
    .o_precharge_after(o_precharge_after),
    .o_pwr_state(o_pwr_state),
    .o_exit_pulse(o_exit_pulse),
    .o_exit_from(o_exit_from),
    .o_illegal(o_illegal)
);
`default_nettype wire

// ==== tb/lpcd_ctrl_model.sv ====
// Behavioural memory controller that drives the command pins.
`timescale 1ns/1ps
`default_nettype none
module lpcd_ctrl_model (
    // System clock used only to pace the pins.
    input wire logic i_clk,
    // Pins toward the device.
    output lpcd_pkg::lpcd_pins_t o_pins
);
    import lpcd_pkg::*;
    // ==========================================================
    // Idle: CK low, deselected, clock enable high, all bits at levels.
    initial begin
        o_pins = '{ck: 1'h0, cs_n: 1'h1, cke: 1'h1, ca: 10'h000};
    end

    // One command: rising half, then falling half, each phase 6 cycles so
    // the device's synchroniser sees both; only encodings the bench asks for.
    task automatic send(input logic cs_n, input logic cke, input logic [9:0] r,
                        input logic [9:0] f);
        @(negedge i_clk);
        o_pins.cs_n = cs_n;
        o_pins.cke = cke;
        o_pins.ca = r;
        o_pins.ck = 1'h1;
        repeat (6) @(negedge i_clk);
        // Select flips on the falling half; the device must ignore it.
        o_pins.cs_n = ~cs_n;
        o_pins.ca = f;
        o_pins.ck = 1'h0;
        repeat (6) @(negedge i_clk);
        // Outside a frame the bits still sit at a level, never the old value.
        o_pins.ca = ~f;
        o_pins.cs_n = 1'h1;
    endtask

    // Change clock enable with CK standing still.
    task automatic set_cke(input logic v);
        @(negedge i_clk);
        o_pins.cke = v;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking testbench of the command decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lpcd_pkg::*;
    logic i_clk = 1'h0;
    logic i_sys_rst = 1'h1;
    lpcd_pins_t pins;
    lpcd_cmd_t o_cmd, cap;
    logic [7:0] o_bank_sel, cap_sel;
    logic o_precharge_after, cap_pa, o_exit_pulse, o_illegal;
    lpcd_pwr_t o_pwr_state, o_exit_from;
    int err_total = 0;
    int total_checks = 0;
    int nval = 0;
    int cyc = 0;

    // ==========================================================
    // 50 MHz clock and the two parties.
    always #10 i_clk = ~i_clk;
    lpcd_ctrl_model u_ctrl (.i_clk(i_clk), .o_pins(pins));
    lpcd_decoder #(.BANKS(8)) u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pins(pins),
        .o_cmd(o_cmd), .o_bank_sel(o_bank_sel), .o_precharge_after(o_precharge_after),
        .o_pwr_state(o_pwr_state), .o_exit_pulse(o_exit_pulse), .o_exit_from(o_exit_from),
        .o_illegal(o_illegal));

    // Capture each decoded command; a hang is cut short after 3000 cycles.
    always @(negedge i_clk) begin
        cyc++;
        if (o_cmd.valid === 1'b1) begin
            cap = o_cmd;
            cap_sel = o_bank_sel;
            cap_pa = o_precharge_after;
            nval++;
        end
        if (cyc == 3000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic lpcd_cmd_t mk(lpcd_kind_t k, logic [2:0] b, logic [14:0] row,
        logic [11:0] col, logic [7:0] a, logic [7:0] p, logic ap, logic ab);
        mk = lpcd_cmd_t'({1'b1, k, b, row, col, a, p, ap, ab});
    endfunction

    // Send one command and compare every field, the bank select and the pulse.
    task automatic run_cmd(input logic cs_n, input logic [9:0] r, input logic [9:0] f,
        input lpcd_cmd_t e, input logic [7:0] sel, input logic pa);
        int n0;
        n0 = nval;
        u_ctrl.send(cs_n, 1'b1, r, f);
        chk(64'(nval - n0), 64'h1);
        chk(64'(cap), 64'(e));
        chk(64'(cap_sel), 64'(sel));
        chk(64'(cap_pa), 64'(pa));
    endtask

    task automatic do_reset();
        @(negedge i_clk);
        i_sys_rst = 1'h1;
        repeat (6) @(negedge i_clk);
        i_sys_rst = 1'h0;
        chk(64'({o_cmd, o_bank_sel, o_precharge_after, o_exit_pulse, o_illegal}), 64'h0);
        chk(64'({o_pwr_state, o_exit_from}), 64'(4'h0));
    endtask

    task automatic t_mode_reg();
        logic [7:0] a = 8'ha5;
        logic [7:0] p = 8'h3c;
        run_cmd(0, {a[5:0], 4'h0}, {p, a[7:6]}, mk(K_MRW, 0, 0, 0, a, p, 0, 0), 0, 0);
        run_cmd(0, {a[5:0], 4'h8}, {p, a[7:6]}, mk(K_MRR, 0, 0, 0, a, 0, 0, 0), 0, 0);
        $display("test mode_reg done");
    endtask

    task automatic t_activate();
        logic [14:0] row = 15'h5a5c;
        run_cmd(0, {3'h5, row[12:8], 2'b10}, {row[14:13], row[7:0]},
            mk(K_ACT, 3'h5, row, 0, 0, 0, 0, 0), 8'h20, 0);
        $display("test activate done");
    endtask

    // Write without and read with auto precharge; odd column shows bit 0 dropped.
    task automatic t_access();
        logic [11:0] c = 12'hb6f;
        for (int i = 0; i < 2; i++) begin
            run_cmd(0, {3'(i + 2), c[2:1], 2'b10, 1'(i), 2'b01}, {c[11:3], 1'(i)},
                mk(i ? K_RD : K_WR, 3'(i + 2), 0, {c[11:1], 1'b0}, 0, 0, 1'(i), 0),
                8'h01 << (i + 2), 1'(i));
        end
        $display("test access done");
    endtask

    task automatic t_bank_cmds();
        run_cmd(0, 10'h38b, 10'h3ff, mk(K_PRE, 3'h7, 0, 0, 0, 0, 0, 0), 8'h80, 0);
        run_cmd(0, 10'h09b, 10'h000, mk(K_PRE, 3'h1, 0, 0, 0, 0, 0, 1), 8'hff, 0);
        run_cmd(0, 10'h184, 10'h2aa, mk(K_REF_PB, 3'h3, 0, 0, 0, 0, 0, 0), 8'h08, 0);
        run_cmd(0, 10'h3fc, 10'h155, mk(K_REF_AB, 0, 0, 0, 0, 0, 0, 0), 0, 0);
        run_cmd(0, 10'h3a7, 10'h155, mk(K_NOP, 0, 0, 0, 0, 0, 0, 0), 0, 0);
        run_cmd(1, 10'h001, 10'h2aa, mk(K_NOP, 0, 0, 0, 0, 0, 0, 0), 0, 0);
        run_cmd(0, 10'h2a3, 10'h155, mk(K_BST, 0, 0, 0, 0, 0, 0, 0), 0, 0);
        $display("test bank_cmds done");
    endtask

    // Enter each low-power state, leave it with CK still, then a deselect exit.
    task automatic t_power();
        logic pc[3] = '{1'b0, 1'b0, 1'b1};
        logic [9:0] pr[3] = '{10'h2ac, 10'h2a3, 10'h155};
        lpcd_kind_t pk[3] = '{K_SELF_REFRESH_IN, K_DPD_IN, K_PD_IN};
        lpcd_pwr_t pp[3] = '{P_SELF_REFRESH, P_DPD, P_PD};
        int n;
        for (int i = 0; i < 3; i++) begin
            u_ctrl.send(pc[i], 1'b0, pr[i], 10'h0f0);
            chk(64'(cap.kind), 64'(pk[i]));
            chk(64'(o_pwr_state), 64'(pp[i]));
            u_ctrl.set_cke(1'b1);
            n = 0;
            while (o_exit_pulse !== 1'b1 && n < 20) begin
                @(negedge i_clk);
                n++;
            end
            chk(64'({o_exit_pulse, o_exit_from, o_pwr_state}), 64'({1'b1, pp[i], P_ON}));
            u_ctrl.send(1'b1, 1'b1, 10'h000, 10'h3ff);
            chk(64'(cap.kind), 64'(K_PD_OUT));
        end
        $display("test power done");
    endtask

    // Clock enable falling with a non-entry pattern, then the required restart.
    task automatic t_illegal();
        u_ctrl.send(1'b0, 1'b0, 10'h001, 10'h000);
        chk(64'({cap.kind, o_illegal}), 64'({K_ILLEGAL, 1'b1}));
        u_ctrl.set_cke(1'b1);
        repeat (10) @(negedge i_clk);
        chk(64'(o_illegal), 64'h1);
        do_reset();
        $display("test illegal done");
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        t_mode_reg();
        t_activate();
        t_access();
        t_bank_cmds();
        t_power();
        t_illegal();
        conclude();
    end
endmodule
`default_nettype wire
